// [fgv_top.sv]
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// [RULE1] vector units truncate small partial products
// [RULE2] inner product of groups 0,4,8,12
// [RULE3] inner product always raises inexact cause/flag
// [RULE4] transform multiplies background matrix into vector
// [RULE5] transform always raises inexact cause/flag
// [RULE6] transform traps whenever invalid enable set
// [RULE7] bank swap one cycle; status load 4 cycles
// [RULE8] size bit set moves register pairs
// [RULE9] size switch changes transfer size bit
// [RULE10] software: paired double moves big-endian only
// [RULE11] nearest rounding misses single tiny underflow
// [RULE12] same missed underflow for double results
// [RULE13] overflow flag on huge vector error bound
// [RULE14] infinite products may give wrong sign
// [RULE15] double add misses inexact in quirk window
// [RULE16] quirk window may round to other neighbour
// [RULE17] size and precision together are reserved
// [RULE18] quiet op clears cause, keeps flags
// [RULE19] swaps invert only their own bit
module fgv_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic bop_done_i,
  input wire logic [5:0] bop_cause_i,
  input wire logic bop_tiny_i,
  input wire logic bop_norm_i,
  input wire logic bop_dadd_i,
  input wire logic [10:0] bop_ediff_i,
  input wire logic [51:0] bop_smant_i,
  output logic [31:0] fp_status_control_reg_o,
  output logic exc_o,
  output logic busy_o
);
  import fgv_pkg::*;

  // ***********************************************************
  // state and registers
  // ***********************************************************
  fgv_state_e st_r, st_nxt;
  logic [31:0] fp_status_control_reg_r, fp_status_control_reg_nxt, cmd_r, mem0_r, mem1_r, dat_r;
  logic ack_r, exc_r, sz_r;
  logic [2:0] wcnt_r, stp_r;
  logic [1:0] row_r, wk_r;
  logic [3:0] op_r, m_r, n_r;
  logic [31:0] res_r [4];
  logic [31:0] da, db;
  logic acc_s_r, inf_r, infs_r, ovf_r, unf_r, inv_r;
  logic signed [11:0] acc_e_r;
  logic [23:0] acc_m_r;

  // ***********************************************************
  // wishbone decode and wait control
  // ***********************************************************
  wire req = cyc_i & stb_i;
  wire idle = (st_r == ST_IDLE);
  wire hit_fp_status_control_reg = (adr_i == ADR_FP_STATUS_CONTROL_REG);
  wire hit_cmd = (adr_i == ADR_CMD);
  wire hit_stat = (adr_i == ADR_STAT);
  wire hit_mem0 = (adr_i == ADR_MEM0);
  wire hit_mem1 = (adr_i == ADR_MEM1);
  wire hit_fpr = adr_i[FPR_WIN_BIT] & (adr_i[1:0] == 2'b00);
  wire need_idle = (we_i & (hit_fp_status_control_reg | hit_cmd | hit_mem0 | hit_mem1))
    | hit_fpr;
  wire may_run = req & ~ack_r & (idle | ~need_idle);
  // status load waits so the unit state settles
  wire [2:0] need = (we_i & hit_fp_status_control_reg) ? LDC_WAIT // RULE7
    : (~we_i & hit_fpr) ? 3'd1 : 3'd0;
  wire go = may_run & (wcnt_r >= need);
  wire wr_stb = go & we_i;
  wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
    {8{sel_i[0]}}};
  wire [31:0] wd_fp_status_control_reg = (fp_status_control_reg_r & ~bmask) | (dat_i & bmask);
  wire [31:0] wd_cmd = (cmd_r & ~bmask) | (dat_i & bmask);
  wire wr_cmd = wr_stb & hit_cmd;
  wire [3:0] new_op = wd_cmd[3:0];
  wire bank = fp_status_control_reg_r[BANK_BIT];
  wire prec = fp_status_control_reg_r[PREC_BIT];
  wire is_ip = (op_r == OP_IPROD);
  wire is_xf = (op_r == OP_XFORM);

  // wait counter and acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i || !may_run) begin
      wcnt_r <= 3'd0;
    end else if (!go) begin
      wcnt_r <= wcnt_r + 3'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= go;
    end
  end

  // read data mux, unmapped addresses read zero
  wire [31:0] rd_mux = hit_fp_status_control_reg ? fp_status_control_reg_r
    : hit_cmd ? cmd_r
    : hit_stat ? {27'h0, ~idle, st_r}
    : hit_mem0 ? mem0_r
    : hit_mem1 ? mem1_r
    : hit_fpr ? da : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0;
    end else if (go && !we_i) begin
      dat_r <= rd_mux;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  wire launch_calc = wr_cmd & ~prec
    & ((new_op == OP_IPROD) | (new_op == OP_XFORM)); // RULE17
  wire launch_move = wr_cmd & ((new_op == OP_MOVRR)
    | (new_op == OP_MOVST) | (new_op == OP_MOVLD));
  wire calc_last = (stp_r == 3'd4) & (is_ip | (row_r == 2'd3));
  wire wbk_last = is_ip | (wk_r == 2'd3);
  wire move_last = (stp_r == 3'd2) | (~sz_r & (stp_r == 3'd1));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (launch_calc) begin
          st_nxt = ST_CALC;
        end else if (launch_move) begin
          st_nxt = ST_MOVE;
        end
      end
      ST_CALC: begin
        if (calc_last) begin
          st_nxt = ST_WBK;
        end
      end
      ST_WBK: begin
        if (wbk_last) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_MOVE: begin
        if (move_last) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // operand fields latched at launch, step counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_r <= 4'h0;
      m_r <= 4'h0;
      n_r <= 4'h0;
      sz_r <= 1'b0;
      stp_r <= 3'd0;
      row_r <= 2'd0;
      wk_r <= 2'd0;
    end else if (idle) begin
      op_r <= new_op;
      m_r <= wd_cmd[7:4];
      n_r <= wd_cmd[11:8];
      sz_r <= fp_status_control_reg_r[SIZE_BIT];
      stp_r <= 3'd0;
      row_r <= 2'd0;
      wk_r <= 2'd0;
    end else if (st_r == ST_CALC && stp_r == 3'd4) begin
      stp_r <= 3'd0;
      row_r <= row_r + 2'd1;
    end else if (st_r == ST_WBK) begin
      wk_r <= wk_r + 2'd1;
    end else begin
      stp_r <= stp_r + 3'd1;
    end
  end

  // ***********************************************************
  // register file ports
  // ***********************************************************
  wire calc = (st_r == ST_CALC);
  wire move = (st_r == ST_MOVE);
  wire wbk = (st_r == ST_WBK);
  // groups start at 0,4,8,12; matrix sits in the background bank
  wire [4:0] ra_calc = is_xf ? {~bank, stp_r[1:0], row_r} // RULE4
    : {bank, m_r[3:2], stp_r[1:0]}; // RULE2
  // pair moves: even pair, odd field picks the background pair
  wire [4:0] ra_move = sz_r ? {bank ^ m_r[0], m_r[3:1], 1'b0} // RULE8
    : {bank, m_r};
  wire [4:0] ra = idle ? adr_i[6:2] : calc ? ra_calc : ra_move;
  wire [4:0] rb = calc ? {bank, n_r[3:2], stp_r[1:0]}
    : {bank ^ m_r[0], m_r[3:1], 1'b1};
  wire [4:0] wa_move = sz_r ? {bank ^ n_r[0], n_r[3:1], stp_r == 3'd2}
    : {bank, n_r};
  wire mv_we = move & (stp_r != 3'd0) & (op_r != OP_MOVST);
  wire rf_we = (idle & wr_stb & hit_fpr) | wbk | mv_we;
  wire [4:0] wa = idle ? adr_i[6:2]
    : wbk ? (is_ip ? {bank, n_r[3:2], 2'b11} : {bank, n_r[3:2], wk_r})
    : wa_move;
  wire [31:0] mv_wd = (op_r == OP_MOVLD)
    ? ((stp_r == 3'd2) ? mem1_r : mem0_r)
    : ((stp_r == 3'd2) ? db : da);
  wire [31:0] rf_wd = idle ? dat_i
    : wbk ? (is_ip ? res_r[0] : res_r[wk_r]) : mv_wd;

  fgv_regmem u_mem (
    .clk_i(clk_i),
    .ra_i(ra),
    .rb_i(rb),
    .da_o(da),
    .db_o(db),
    .we_i(rf_we),
    .wa_i(wa),
    .wd_i(rf_wd)
  );

  // transfer words standing in for memory, first word = even reg
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem0_r <= 32'h0;
      mem1_r <= 32'h0;
    end else if (move && op_r == OP_MOVST && stp_r == 3'd1) begin
      mem0_r <= da;
      mem1_r <= sz_r ? db : mem1_r; // RULE8
    end else if (wr_stb && hit_mem0) begin
      mem0_r <= (mem0_r & ~bmask) | (dat_i & bmask);
    end else if (wr_stb && hit_mem1) begin
      mem1_r <= (mem1_r & ~bmask) | (dat_i & bmask);
    end
  end

  // ***********************************************************
  // approximate product and accumulate
  // ***********************************************************
  function automatic logic [4:0] fgv_lzc(input logic [23:0] v);
    logic [4:0] n;
    logic hit;
    n = 5'd0;
    hit = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      if (!hit && !v[i]) begin
        n = n + 5'd1;
      end else begin
        hit = 1'b1;
      end
    end
    return n;
  endfunction : fgv_lzc

  wire [7:0] ea = da[30:23];
  wire [7:0] eb = db[30:23];
  // denormals carry no hidden bit, so 23 significant digits
  wire [23:0] ma = {|ea, da[22:0]}; // RULE1
  wire [23:0] mb = {|eb, db[22:0]};
  wire [47:0] p48 = ma * mb;
  wire [7:0] eaf = (|ea) ? ea : 8'h01;
  wire [7:0] ebf = (|eb) ? eb : 8'h01;
  wire signed [11:0] pe = $signed({4'h0, eaf}) + $signed({4'h0, ebf})
    - $signed(EXP_BIAS) + (p48[47] ? 12'sd1 : 12'sd0);
  // low half of the partial products is dropped
  wire [23:0] pm = p48[47] ? p48[47:24] : p48[46:23]; // RULE1
  wire ps = da[31] ^ db[31];
  wire pinf = (ea == 8'hff) | (eb == 8'hff);
  wire pnan = ((ea == 8'hff) & |da[22:0]) | ((eb == 8'hff) & |db[22:0]);
  wire pbig = (acc_m_r == 24'h0) | (pe > acc_e_r)
    | ((pe == acc_e_r) & (pm > acc_m_r));
  wire signed [11:0] be = pbig ? pe : acc_e_r;
  wire signed [11:0] shd = pbig ? (pe - acc_e_r) : (acc_e_r - pe);
  wire [23:0] bm = pbig ? pm : acc_m_r;
  wire [23:0] sm0 = pbig ? acc_m_r : pm;
  wire [23:0] sm = (shd > 12'sd24) ? 24'h0 : (sm0 >> shd[4:0]);
  wire bs = pbig ? ps : acc_s_r;
  wire [24:0] sum = (ps == acc_s_r) ? ({1'b0, bm} + {1'b0, sm})
    : ({1'b0, bm} - {1'b0, sm});
  wire [4:0] lz = fgv_lzc(sum[23:0]);
  wire [23:0] n_m = sum[24] ? sum[24:1] : (sum[23:0] << lz);
  wire signed [11:0] n_e = sum[24] ? (be + 12'sd1)
    : (be - $signed({7'h0, lz}));
  wire take = calc & (stp_r != 3'd0);
  wire nx_inf = inf_r | pinf;
  // first infinite product decides the sign
  wire nx_infs = inf_r ? infs_r : ps; // RULE14
  wire p_huge = take & (pe > $signed(EXP_TOP)); // RULE13
  wire pk_ovf = (n_m != 24'h0) & (n_e > $signed(EXP_TOP));
  wire pk_unf = (n_m != 24'h0) & (n_e < 12'sd1);
  wire [31:0] pk = nx_inf ? {nx_infs, 8'hff, 23'h0}
    : (pk_ovf ? {bs, 8'hff, 23'h0}
    : ((n_m == 24'h0) | pk_unf) ? {bs, 31'h0}
    : {bs, n_e[7:0], n_m[22:0]});

  // accumulator and per-op event flags
  always_ff @(posedge clk_i) begin
    if (rst_i || idle || (calc && stp_r == 3'd4)) begin
      acc_s_r <= 1'b0;
      acc_e_r <= 12'sd0;
      acc_m_r <= 24'h0;
      inf_r <= 1'b0;
      infs_r <= 1'b0;
    end else if (take) begin
      acc_s_r <= bs;
      acc_e_r <= n_e;
      acc_m_r <= n_m;
      inf_r <= nx_inf;
      infs_r <= nx_infs;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || idle) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      inv_r <= 1'b0;
    end else if (take) begin
      ovf_r <= ovf_r | p_huge | ((stp_r == 3'd4) & pk_ovf); // RULE13
      unf_r <= unf_r | ((stp_r == 3'd4) & pk_unf);
      inv_r <= inv_r | pnan;
    end
  end

  always_ff @(posedge clk_i) begin
    if (calc && stp_r == 3'd4) begin
      res_r[row_r] <= pk;
    end
  end

  // ***********************************************************
  // exception cause and flag update
  // ***********************************************************
  wire g_fin = wbk & wbk_last;
  // approximate results are always inexact
  wire [5:0] g_cause = {1'b0, inv_r, 1'b0, ovf_r, unf_r, 1'b1}; // RULE3 RULE5
  wire near_rnd = (fp_status_control_reg_r[RND_LSB+1:RND_LSB] == 2'b00);
  // tiny but normalized after nearest rounding: no underflow
  wire miss_u = near_rnd & bop_tiny_i & bop_norm_i; // RULE11 RULE12
  // double add window may also round to the other neighbour
  wire miss_i = bop_dadd_i & (bop_ediff_i >= DQ_EDIFF_LO)
    & (bop_ediff_i <= DQ_EDIFF_HI) & (|bop_smant_i[31:24])
    & ~(|bop_smant_i[23:0]) & ~(|bop_smant_i[40:32]); // RULE15 RULE16
  wire [5:0] b_cause = bop_cause_i
    & ~{4'h0, miss_u, 1'b0} & ~{5'h0, miss_i};
  wire fin = g_fin | bop_done_i;
  wire [5:0] fin_cause = (g_fin ? g_cause : 6'h0)
    | (bop_done_i ? b_cause : 6'h0);
  wire [4:0] en = fp_status_control_reg_r[EN_LSB+4:EN_LSB];
  wire trap = fin & (fin_cause[XE] | |(fin_cause[4:0] & en)
    | (g_fin & is_xf & en[XV])); // RULE6

  always_comb begin
    fp_status_control_reg_nxt = fp_status_control_reg_r;
    if (wr_stb && hit_fp_status_control_reg) begin
      fp_status_control_reg_nxt = wd_fp_status_control_reg & FP_STATUS_CONTROL_REG_WMASK; // RULE7
    end
    if (wr_cmd && idle && new_op == OP_BSWAP) begin
      fp_status_control_reg_nxt[BANK_BIT] = ~fp_status_control_reg_r[BANK_BIT]; // RULE7 RULE19
    end
    if (wr_cmd && idle && new_op == OP_SSWAP) begin
      fp_status_control_reg_nxt[SIZE_BIT] = ~fp_status_control_reg_r[SIZE_BIT]; // RULE9 RULE19
    end
    if (fin) begin
      // cause replaced each op, flags only accumulate
      fp_status_control_reg_nxt[CAUSE_LSB+5:CAUSE_LSB] = fin_cause; // RULE18
      fp_status_control_reg_nxt[FLAG_LSB+4:FLAG_LSB] = fp_status_control_reg_nxt[FLAG_LSB+4:FLAG_LSB]
        | fin_cause[4:0]; // RULE3 RULE5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fp_status_control_reg_r <= FP_STATUS_CONTROL_REG_RST;
      cmd_r <= 32'h0;
      exc_r <= 1'b0;
    end else begin
      fp_status_control_reg_r <= fp_status_control_reg_nxt;
      cmd_r <= wr_cmd ? wd_cmd : cmd_r;
      exc_r <= trap;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign fp_status_control_reg_o = fp_status_control_reg_r;
  assign exc_o = exc_r;
  assign busy_o = ~idle;
endmodule : fgv_top

// [fgv_pkg.sv]
package fgv_pkg;
  // ***********************************************************
  // register map (byte addresses on the wishbone bus)
  // ***********************************************************
  localparam logic [7:0] ADR_FP_STATUS_CONTROL_REG = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_MEM0 = 8'h0c;
  localparam logic [7:0] ADR_MEM1 = 8'h10;
  localparam int FPR_WIN_BIT = 7;
  // ***********************************************************
  // fp_status_control_reg layout
  // ***********************************************************
  localparam int BANK_BIT = 21;
  localparam int SIZE_BIT = 20;
  localparam int PREC_BIT = 19;
  localparam int CAUSE_LSB = 12;
  localparam int EN_LSB = 7;
  localparam int FLAG_LSB = 2;
  localparam int RND_LSB = 0;
  localparam logic [31:0] FP_STATUS_CONTROL_REG_RST = 32'h00040001;
  localparam logic [31:0] FP_STATUS_CONTROL_REG_WMASK = 32'h003fffff;
  // cause bit order inside the six-bit cause group
  localparam int XI = 0;
  localparam int XU = 1;
  localparam int XO = 2;
  localparam int XV = 4;
  localparam int XE = 5;
  // ***********************************************************
  // command opcodes (command register bits 3:0)
  // ***********************************************************
  localparam logic [3:0] OP_IPROD = 4'h1;
  localparam logic [3:0] OP_XFORM = 4'h2;
  localparam logic [3:0] OP_BSWAP = 4'h3;
  localparam logic [3:0] OP_SSWAP = 4'h4;
  localparam logic [3:0] OP_MOVRR = 4'h5;
  localparam logic [3:0] OP_MOVST = 4'h6;
  localparam logic [3:0] OP_MOVLD = 4'h7;
  // ***********************************************************
  // timing and quirk constants
  // ***********************************************************
  localparam logic [2:0] LDC_WAIT = 3'd3;
  localparam logic [10:0] DQ_EDIFF_LO = 11'd43;
  localparam logic [10:0] DQ_EDIFF_HI = 11'd50;
  localparam logic [11:0] EXP_BIAS = 12'd127;
  localparam logic [11:0] EXP_TOP = 12'd254;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CALC = 4'b0010,
    ST_WBK = 4'b0100,
    ST_MOVE = 4'b1000
  } fgv_state_e;
endpackage : fgv_pkg

// [fgv_regmem.sv]
`timescale 1ns/1ps
// ***********************************************************
// two banks of sixteen float registers, two registered reads
// ***********************************************************
module fgv_regmem (
  input wire logic clk_i,
  input wire logic [4:0] ra_i,
  input wire logic [4:0] rb_i,
  output logic [31:0] da_o,
  output logic [31:0] db_o,
  input wire logic we_i,
  input wire logic [4:0] wa_i,
  input wire logic [31:0] wd_i
);
  logic [31:0] mem [32];

  // write port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end

  // read data come out of registers
  always_ff @(posedge clk_i) begin
    da_o <= mem[ra_i];
    db_o <= mem[rb_i];
  end
endmodule : fgv_regmem

// [fgv_top_props.sv]
`timescale 1ns/1ps
// ***********************************************************
// checker on the top ports
// ***********************************************************
module fgv_top_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic bop_done_i,
  input wire logic [5:0] bop_cause_i,
  input wire logic bop_tiny_i,
  input wire logic bop_norm_i,
  input wire logic bop_dadd_i,
  input wire logic [10:0] bop_ediff_i,
  input wire logic [51:0] bop_smant_i,
  input wire logic [31:0] fp_status_control_reg_o,
  input wire logic exc_o,
  input wire logic busy_o
);
  import fgv_pkg::*;
  logic [3:0] last_op_r;
  logic wr_req;
  logic vec_op;
  // named request and command decodes
  assign wr_req = cyc_i && stb_i && we_i;
  assign vec_op = last_op_r == OP_IPROD || last_op_r == OP_XFORM;
  // last command accepted on the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_op_r <= 4'h0;
    end else if (ack_o && wr_req && adr_i == ADR_CMD) begin
      last_op_r <= dat_i[3:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bank_toggle: assert property (
    ack_o && $past(wr_req && adr_i == ADR_CMD && dat_i[3:0] == OP_BSWAP)
    |-> fp_status_control_reg_o[BANK_BIT] != $past(fp_status_control_reg_o[BANK_BIT])
    && fp_status_control_reg_o[SIZE_BIT] == $past(fp_status_control_reg_o[SIZE_BIT]))
    else $error("bank bit not toggled alone");
  a_size_toggle: assert property (
    ack_o && $past(wr_req && adr_i == ADR_CMD && dat_i[3:0] == OP_SSWAP)
    |-> fp_status_control_reg_o[SIZE_BIT] != $past(fp_status_control_reg_o[SIZE_BIT])
    && fp_status_control_reg_o[BANK_BIT] == $past(fp_status_control_reg_o[BANK_BIT]))
    else $error("size bit not toggled alone");
  a_load_wait: assert property (
    $rose(wr_req) && adr_i == ADR_FP_STATUS_CONTROL_REG && !busy_o
    |-> ##1 !ack_o [*3] ##1 ack_o)
    else $error("status load not acked in cycle four");
  a_quiet_clear: assert property (
    bop_done_i && bop_cause_i == 6'h00 && !wr_req && !busy_o
    |=> fp_status_control_reg_o[CAUSE_LSB +: 6] == 6'h00
    && fp_status_control_reg_o[FLAG_LSB +: 5] == $past(fp_status_control_reg_o[FLAG_LSB +: 5]))
    else $error("quiet op did not clear cause or kept no flags");
  a_tiny_no_uf: assert property (
    bop_done_i && fp_status_control_reg_o[1:0] == 2'b00 && bop_tiny_i && bop_norm_i
    && !bop_dadd_i && !wr_req && !busy_o
    |=> !fp_status_control_reg_o[CAUSE_LSB + XU]
    && fp_status_control_reg_o[CAUSE_LSB + XI] == $past(bop_cause_i[XI]))
    else $error("tiny rounded result set underflow");
  a_dadd_noinex: assert property (
    bop_done_i && bop_dadd_i && bop_ediff_i >= DQ_EDIFF_LO
    && bop_ediff_i <= DQ_EDIFF_HI && |bop_smant_i[31:24]
    && bop_smant_i[23:0] == 24'h0 && bop_smant_i[40:32] == 9'h0
    && !wr_req && !busy_o
    |=> !fp_status_control_reg_o[CAUSE_LSB + XI])
    else $error("double add window set inexact");
  a_vec_inexact: assert property (
    $fell(busy_o) && vec_op
    |-> ##[0:1] (fp_status_control_reg_o[CAUSE_LSB + XI] && fp_status_control_reg_o[FLAG_LSB + XI]))
    else $error("vector op left inexact clear");
  a_vec_trap: assert property (
    $fell(busy_o) && (vec_op && fp_status_control_reg_o[EN_LSB + XI]
    || last_op_r == OP_XFORM && fp_status_control_reg_o[EN_LSB + XV])
    |-> ##[0:2] exc_o)
    else $error("vector op raised no exception");
endmodule : fgv_top_props

bind fgv_top fgv_top_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .bop_done_i(bop_done_i), .bop_cause_i(bop_cause_i),
  .bop_tiny_i(bop_tiny_i), .bop_norm_i(bop_norm_i), .bop_dadd_i(bop_dadd_i),
  .bop_ediff_i(bop_ediff_i), .bop_smant_i(bop_smant_i),
  .fp_status_control_reg_o(fp_status_control_reg_o), .exc_o(exc_o), .busy_o(busy_o));

// [fgv_core_model.sv]
`timescale 1ns/1ps
// ***********************************************************
// core side: basic arithmetic unit finishing ops
// ***********************************************************
module fgv_core_model (
  input wire logic clk_i,
  output logic done_o,
  output logic [5:0] cause_o,
  output logic tiny_o,
  output logic norm_o,
  output logic dadd_o,
  output logic [10:0] ediff_o,
  output logic [51:0] smant_o
);
  initial begin
    done_o = 1'b0;
    {cause_o, tiny_o, norm_o, dadd_o, ediff_o, smant_o} = '0;
  end
  // one finish pulse; fields scrambled once no longer valid
  task fire(input logic [5:0] c, input logic t, input logic n,
            input logic d, input logic [10:0] e, input logic [51:0] s);
    @(posedge clk_i);
    done_o <= 1'b1;
    {cause_o, tiny_o, norm_o, dadd_o, ediff_o, smant_o} <= {c, t, n, d, e, s};
    @(posedge clk_i);
    done_o <= 1'b0;
    {cause_o, tiny_o, norm_o, dadd_o, ediff_o, smant_o}
      <= ~{c, t, n, d, e, s};
    @(posedge clk_i);
  endtask : fire
endmodule : fgv_core_model

// [fgv_top_tb.sv]
`timescale 1ns/1ps
// ***********************************************************
// self-checking bench for the vector unit
// ***********************************************************
module fgv_top_tb;
  import fgv_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] dat_o, fp_status_control_reg_o, q;
  logic ack_o, exc_o, busy_o, done, tiny, norm, dadd;
  logic [5:0] cause;
  logic [10:0] ediff;
  logic [51:0] smant;
  int errors = 0;
  int total_checks = 0;
  int exc_cnt = 0;
  int n, e0;
  // clock and exception pulse counter
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (exc_o === 1'b1) exc_cnt++;
  end
  fgv_core_model u_core (.clk_i(clk_i), .done_o(done), .cause_o(cause),
    .tiny_o(tiny), .norm_o(norm), .dadd_o(dadd), .ediff_o(ediff),
    .smant_o(smant));
  fgv_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(dat_o), .we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack_o), .bop_done_i(done), .bop_cause_i(cause),
    .bop_tiny_i(tiny), .bop_norm_i(norm), .bop_dadd_i(dadd),
    .bop_ediff_i(ediff), .bop_smant_i(smant), .fp_status_control_reg_o(fp_status_control_reg_o),
    .exc_o(exc_o), .busy_o(busy_o));
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // classic wishbone cycle; q gets read data, n edges up to ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 300);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack_o !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask : wb
  task wait_idle;
    int k;
    k = 0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 300) begin
      errors++;
      end_of_test();
    end
  endtask : wait_idle
  task wcmd(input logic [31:0] c);
    wb(1'b1, ADR_CMD, c);
    wait_idle();
  endtask : wcmd
  task wfpr(input int k, input logic [31:0] v);
    wb(1'b1, 8'(128 + 4 * k), v);
  endtask : wfpr
  task rfpr(input int k);
    wb(1'b0, 8'(128 + 4 * k), 32'h0);
  endtask : rfpr
  task t_reset;
    wb(1'b0, ADR_FP_STATUS_CONTROL_REG, 32'h0);
    chk("fp_status_control_reg read", q, FP_STATUS_CONTROL_REG_RST);
    chk("fp_status_control_reg out", fp_status_control_reg_o, FP_STATUS_CONTROL_REG_RST);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b0, ADR_STAT, 32'h0);
    chk("stat idle", q, 32'h00000001);
  endtask : t_reset
  task t_swaps;
    wb(1'b1, ADR_CMD, {28'h0, OP_BSWAP});
    chk("swap ack", 32'(n), 32'h2);
    wait_idle();
    chk("bank", fp_status_control_reg_o, FP_STATUS_CONTROL_REG_RST ^ 32'h00200000);
    wcmd({28'h0, OP_SSWAP});
    chk("size", fp_status_control_reg_o, FP_STATUS_CONTROL_REG_RST ^ 32'h00300000);
    wcmd({28'h0, OP_BSWAP});
    wcmd({28'h0, OP_SSWAP});
    chk("back", fp_status_control_reg_o, FP_STATUS_CONTROL_REG_RST);
  endtask : t_swaps
  task t_load;
    wb(1'b1, ADR_FP_STATUS_CONTROL_REG, 32'hffc00880);
    chk("load ack", 32'(n), 32'h5);
    wb(1'b0, ADR_FP_STATUS_CONTROL_REG, 32'h0);
    chk("load read", q, 32'h00000880);
  endtask : t_load
  task t_iprod;
    for (int k = 0; k < 8; k++) wfpr(k, k < 4 ? 32'h3f800000 : 32'h40000000);
    e0 = exc_cnt;
    wcmd(32'h00000401);
    chk("iprod fp_status_control_reg", fp_status_control_reg_o, 32'h00001884);
    rfpr(7);
    chk("iprod sum", q, 32'h41000000);
    chk("iprod trap", 32'(exc_cnt - e0), 32'h1);
  endtask : t_iprod
  task t_xform;
    wb(1'b1, ADR_FP_STATUS_CONTROL_REG, 32'h00000800);
    for (int k = 16; k < 32; k++) wfpr(k, 32'h0);
    e0 = exc_cnt;
    wcmd(32'h00000002);
    chk("xform fp_status_control_reg", fp_status_control_reg_o, 32'h00001804);
    rfpr(0);
    chk("xform res", q, 32'h0);
    chk("xform trap", 32'(exc_cnt - e0), 32'h1);
  endtask : t_xform
  task t_move;
    wcmd({28'h0, OP_SSWAP});
    wb(1'b1, ADR_MEM0, 32'h11111111);
    wb(1'b1, ADR_MEM1, 32'h22222222);
    wcmd(32'h00000207);
    rfpr(2);
    chk("pair even", q, 32'h11111111);
    rfpr(3);
    chk("pair odd", q, 32'h22222222);
    wb(1'b1, ADR_MEM0, 32'h0);
    wb(1'b1, ADR_MEM1, 32'h0);
    wcmd(32'h00000026);
    wb(1'b0, ADR_MEM0, 32'h0);
    chk("store even", q, 32'h11111111);
    wb(1'b0, ADR_MEM1, 32'h0);
    chk("store odd", q, 32'h22222222);
    wcmd(32'h00000425);
    rfpr(4);
    chk("copy even", q, 32'h11111111);
    rfpr(5);
    chk("copy odd", q, 32'h22222222);
    wcmd({28'h0, OP_SSWAP});
  endtask : t_move
  task t_fold;
    wb(1'b1, ADR_FP_STATUS_CONTROL_REG, 32'h0);
    u_core.fire(6'h03, 1'b1, 1'b1, 1'b0, 11'h0, 52'h0);
    chk("tiny", fp_status_control_reg_o, 32'h00001004);
    u_core.fire(6'h00, 1'b0, 1'b0, 1'b0, 11'h0, 52'h0);
    chk("quiet", fp_status_control_reg_o, 32'h00000004);
    u_core.fire(6'h01, 1'b0, 1'b0, 1'b1, 11'h02d, 52'h0000001000000);
    chk("dadd", fp_status_control_reg_o, 32'h00000004);
  endtask : t_fold
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_swaps();
    t_load();
    t_iprod();
    t_xform();
    t_move();
    t_fold();
    end_of_test();
  end
endmodule : fgv_top_tb
